// ===== rtl/sfl_pkg.sv
// Shared constants and types of the serial flash block.
package sfl_pkg;
   localparam int          MEM_AW            = 16;
   localparam logic [16:0] MEM_BYTES         = 17'h1_0000;
   localparam logic [16:0] SECT_BYTES        = 17'h0_8000;
   localparam logic [16:0] PAGE_BYTES        = 17'h0_0100;
   localparam logic [7:0]  ERASED_BYTE       = 8'hFF;
   localparam logic [7:0]  NOP_CMD           = 8'h00;
   localparam logic [7:0]  WRITE_ENABLE_CMD  = 8'h06;
   localparam logic [7:0]  WRITE_DISABLE_CMD = 8'h04;
   localparam logic [7:0]  STATUS_READ_CMD   = 8'h05;
   localparam logic [7:0]  STATUS_WRITE_CMD  = 8'h01;
   localparam logic [7:0]  READ_DATA_CMD     = 8'h03;
   localparam logic [7:0]  PAGE_PROGRAM_CMD  = 8'h02;
   localparam logic [7:0]  SECTOR_ERASE_CMD  = 8'hD8;
   localparam logic [7:0]  BULK_ERASE_CMD    = 8'hC7;
   localparam int          BUSY_FLAG_BIT     = 0;
   localparam int          WEL_BIT           = 1;
   localparam int          BP_LO_BIT         = 2;
   localparam int          BP_HI_BIT         = 3;
   localparam int          STATUS_PROT_BIT   = 7;
   localparam logic [1:0]  LAST_ADDR_BYTE    = 2'h2;
   localparam logic [3:0]  REG_STATUS_OFS    = 4'h0;
   localparam logic [3:0]  REG_SRW_OFS       = 4'h4;
   localparam logic [15:0] SRW_CYCLES_RST    = 16'h0010;
   localparam int          REG_SRW_W_MAX     = 16;

   typedef enum logic [2:0] {
      PH_CMD     = 3'b000,
      PH_ADDR    = 3'b001,
      PH_READ    = 3'b010,
      PH_PROG    = 3'b011,
      PH_STAT_RD = 3'b100,
      PH_STAT_WR = 3'b101,
      PH_DONE    = 3'b110
   } sfl_phase_t;

   typedef enum logic [1:0] {
      ENG_IDLE  = 2'b00,
      ENG_PROG  = 2'b01,
      ENG_ERASE = 2'b10,
      ENG_SRWR  = 2'b11
   } sfl_eng_t;
endpackage

// ===== rtl/sfl_pin_sync.sv
// Two-flop synchroniser for the serial pins.
`timescale 1ns/1ps
module sfl_pin_sync #(
   parameter int W = 5
) (
   input  wire logic         ref_clk_in,
   input  wire logic         arst_n_in,
   input  wire logic [W-1:0] pins_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_r;

   if (W < 1) begin : g_chk
      $error("Synchroniser width must be at least one.");
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         meta_r   <= '0;
         sync_out <= '0;
      end else begin
         meta_r   <= pins_in;
         sync_out <= meta_r;
      end
   end
endmodule

// ===== rtl/sfl_avs_regs.sv
// Avalon-MM register slave of the serial flash block.
`timescale 1ns/1ps
module sfl_avs_regs import sfl_pkg::*; #(
   parameter int SRW_W = 16
) (
   input  wire logic             ref_clk_in,
   input  wire logic             arst_n_in,
   input  wire logic [3:0]       avs_address_in,
   input  wire logic             avs_read_in,
   input  wire logic             avs_write_in,
   input  wire logic [31:0]      avs_writedata_in,
   input  wire logic [3:0]       avs_byteenable_in,
   input  wire logic [8:0]       status_in,
   output logic      [31:0]      avs_readdata_out,
   output logic                  avs_waitrequest_out,
   output logic      [SRW_W-1:0] srw_cycles_out
);
   logic [15:0] cur_w;
   logic [15:0] merge_w;

   if (SRW_W < 1 || SRW_W > REG_SRW_W_MAX) begin : g_chk
      $error("Status write cycle width out of range.");
   end

   assign cur_w   = 16'(srw_cycles_out);
   assign merge_w = {avs_byteenable_in[1] ? avs_writedata_in[15:8] : cur_w[15:8],
                     avs_byteenable_in[0] ? avs_writedata_in[7:0] : cur_w[7:0]};

   // One wait cycle per access keeps read data registered and the decode simple.
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         avs_waitrequest_out <= 1'b1;
      end else if ((avs_read_in || avs_write_in) && avs_waitrequest_out) begin
         avs_waitrequest_out <= 1'b0;
      end else begin
         avs_waitrequest_out <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         avs_readdata_out <= 32'h0000_0000;
      end else if (avs_read_in && avs_waitrequest_out) begin
         unique case (avs_address_in)
            REG_STATUS_OFS: avs_readdata_out <= {23'h00_0000, status_in};
            REG_SRW_OFS:    avs_readdata_out <= {16'h0000, cur_w};
            default:        avs_readdata_out <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         srw_cycles_out <= SRW_W'(SRW_CYCLES_RST);
      end else if (avs_write_in && !avs_waitrequest_out && avs_address_in == REG_SRW_OFS) begin
         srw_cycles_out <= SRW_W'(merge_w);
      end
   end
endmodule

// ===== rtl/sfl_flash.sv
// Serial flash device: pin protocol, memory array and internal write engine.
// What this block does
// - Serial input bits are sampled on rising edges of the serial clock.
// - Serial output changes on falling edges of the serial clock.
// - While select is high the device is idle unless a started write cycle is still running, and its output floats.
// - A started erase, program or status write finishes despite select rising.
// - Instructions are ignored until select has gone from high to low.
// - Pause low while selected floats the output and ignores clock and input.
// - Write-protect with status-protect blocks status writes; block-protect 11 blocks program and erase, 01 blocks bulk erase only, 10 blocks nothing.
// - Clock idle low or idle high both work; rise samples, fall drives.
// - Storage is 65,536 bytes as 256 pages of 256 bytes.
// - Sector zero is 00000h-07FFFh, sector one 08000h-0FFFFh.
// - Programming only clears bits; erase is per sector or whole array.
// - Write enable then a four byte page program header and data.
// - One page program writes up to 256 consecutive bytes in one page.
// - Erase leaves every affected byte at FFh and runs an internal cycle.
// - Erase instructions need a prior write enable.
// - Busy flag is set during status write, program and erase cycles.
// - Instructions, addresses and data move most significant bit first.
// - Program, erase and status write need a whole number of bytes clocked.
// - Write enable latch clears at reset, on write disable and after each executed program, erase or status write.
//
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module sfl_flash import sfl_pkg::*; #(
   parameter int SRW_W = 16
) (
   input  wire logic        ref_clk_in,
   input  wire logic        arst_n_in,
   input  wire logic        spi_clk_in,
   input  wire logic        chip_sel_n_in,
   input  wire logic        serial_in,
   input  wire logic        hold_n_in,
   input  wire logic        write_protect_n_in,
   output logic             serial_out_out,
   output logic             serial_out_oe_out,
   input  wire logic [3:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic      [31:0] avs_readdata_out,
   output logic             avs_waitrequest_out
);
   logic             sclk_s, cs_n_s, si_s, hold_n_s, wp_n_s;
   logic             sclk_d_r, cs_d_r, armed_r, hold_r;
   logic             rise, fall, cs_rise, sel, en_rise, en_fall, byte_end;
   logic [2:0]       bit_r;
   logic [7:0]       sh_r, byte_w, cmd_r, new_sr_r, out_sh_r, status_w;
   logic [1:0]       abyte_r, bp_r;
   logic [15:0]      addr_r, cur_w, last_addr_w;
   logic             hdr_done_r, data_seen_r, got_sr_r, so_r, oe_r, shown_r;
   logic             wel_r, srp_r, busy_w, exec, out_ph;
   logic             do_write_enable_cmd, do_write_disable_cmd, do_pp, do_se, do_be, do_status_write_cmd;
   sfl_phase_t       phase_r;
   sfl_eng_t         eng_r;
   logic [16:0]      walk_r, len_r;
   logic [15:0]      base_r;
   logic [SRW_W-1:0] srw_cycles;
   logic [7:0]       mem_r [MEM_BYTES];
   logic [7:0]       pbuf_r [PAGE_BYTES];
   logic [255:0]     pmask_r;

   if (SRW_W < 1 || SRW_W > REG_SRW_W_MAX) begin : g_chk
      $error("Status write cycle width out of range.");
   end

   function automatic sfl_phase_t cmd_phase(input logic [7:0] b, input logic busy);
      sfl_phase_t ph;
      ph = PH_DONE;
      if (!busy || b == STATUS_READ_CMD) begin
         unique case (b)
            READ_DATA_CMD, PAGE_PROGRAM_CMD, SECTOR_ERASE_CMD: ph = PH_ADDR;
            STATUS_READ_CMD:  ph = PH_STAT_RD;
            STATUS_WRITE_CMD: ph = PH_STAT_WR;
            default:          ph = PH_DONE;
         endcase
      end
      return ph;
   endfunction

   sfl_pin_sync #(.W(5)) u_sync (
      .ref_clk_in (ref_clk_in),
      .arst_n_in  (arst_n_in),
      .pins_in    ({spi_clk_in, chip_sel_n_in, serial_in, hold_n_in, write_protect_n_in}),
      .sync_out   ({sclk_s, cs_n_s, si_s, hold_n_s, wp_n_s})
   );

   sfl_avs_regs #(.SRW_W(SRW_W)) u_regs (
      .ref_clk_in          (ref_clk_in),
      .arst_n_in           (arst_n_in),
      .avs_address_in      (avs_address_in),
      .avs_read_in         (avs_read_in),
      .avs_write_in        (avs_write_in),
      .avs_writedata_in    (avs_writedata_in),
      .avs_byteenable_in   (avs_byteenable_in),
      .status_in           ({armed_r, status_w}),
      .avs_readdata_out    (avs_readdata_out),
      .avs_waitrequest_out (avs_waitrequest_out),
      .srw_cycles_out      (srw_cycles)
   );

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sclk_d_r <= 1'b0;
         cs_d_r   <= 1'b0;
      end else begin
         sclk_d_r <= sclk_s;
         cs_d_r   <= cs_n_s;
      end
   end

   // Only edges matter, so the idle level of the clock is irrelevant.
   assign rise     = sclk_s & ~sclk_d_r;
   assign fall     = ~sclk_s & sclk_d_r;
   assign cs_rise  = cs_n_s & ~cs_d_r;
   assign sel      = ~cs_n_s & armed_r & ~hold_r;
   assign en_rise  = sel & rise;
   assign en_fall  = sel & fall;
   assign byte_w   = {sh_r[6:0], si_s};
   assign byte_end = en_rise & (bit_r == 3'h7);
   assign busy_w   = (eng_r != ENG_IDLE);
   assign out_ph   = (phase_r == PH_READ) || (phase_r == PH_STAT_RD);
   assign cur_w    = base_r + walk_r[15:0];
   assign last_addr_w = {addr_r[7:0], byte_w};

   always_comb begin
      status_w                  = 8'h00;
      status_w[BUSY_FLAG_BIT]   = busy_w;
      status_w[WEL_BIT]         = wel_r;
      status_w[BP_LO_BIT]       = bp_r[0];
      status_w[BP_HI_BIT]       = bp_r[1];
      status_w[STATUS_PROT_BIT] = srp_r;
   end

   // A power-up with select already low stays locked out until select cycles.
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         armed_r <= 1'b0;
      end else if (~cs_n_s & cs_d_r) begin
         armed_r <= 1'b1;
      end
   end

   // While selected, pause takes and leaves effect only while the serial clock is low; deselect ends it at once.
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         hold_r <= 1'b0;
      end else if (cs_n_s) begin
         hold_r <= 1'b0;
      end else if (!sclk_s) begin
         hold_r <= ~hold_n_s;
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         bit_r <= 3'h0;
         sh_r  <= 8'h00;
      end else if (cs_n_s) begin
         bit_r <= 3'h0;
      end else if (en_rise) begin
         bit_r <= bit_r + 3'h1;
         sh_r  <= byte_w;
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         phase_r     <= PH_CMD;
         cmd_r       <= NOP_CMD;
         abyte_r     <= 2'h0;
         addr_r      <= 16'h0000;
         hdr_done_r  <= 1'b0;
         data_seen_r <= 1'b0;
         got_sr_r    <= 1'b0;
         new_sr_r    <= 8'h00;
      end else if (cs_n_s) begin
         phase_r <= PH_CMD;
         abyte_r <= 2'h0;
         if (cs_rise) begin
            cmd_r       <= NOP_CMD;
            hdr_done_r  <= 1'b0;
            data_seen_r <= 1'b0;
            got_sr_r    <= 1'b0;
         end
      end else if (byte_end) begin
         unique case (phase_r)
            PH_CMD: begin
               cmd_r   <= (busy_w && byte_w != STATUS_READ_CMD) ? NOP_CMD : byte_w;
               phase_r <= cmd_phase(byte_w, busy_w);
            end
            PH_ADDR: begin
               addr_r  <= last_addr_w;
               abyte_r <= abyte_r + 2'h1;
               if (abyte_r == LAST_ADDR_BYTE) begin
                  hdr_done_r <= 1'b1;
                  if (cmd_r == READ_DATA_CMD) begin
                     phase_r <= PH_READ;
                     addr_r  <= last_addr_w + 16'h0001;
                  end else begin
                     phase_r <= (cmd_r == PAGE_PROGRAM_CMD) ? PH_PROG : PH_DONE;
                  end
               end
            end
            PH_READ: addr_r <= addr_r + 16'h0001;
            PH_PROG: begin
               addr_r[7:0] <= addr_r[7:0] + 8'h01;
               data_seen_r <= 1'b1;
            end
            PH_STAT_WR: begin
               new_sr_r <= byte_w;
               got_sr_r <= 1'b1;
               phase_r  <= PH_DONE;
            end
            PH_STAT_RD, PH_DONE: begin
               phase_r <= phase_r;
            end
         endcase
      end
   end

   // Bytes are loaded at a rising edge and shifted out on the next eight falls.
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         out_sh_r <= 8'h00;
         so_r     <= 1'b0;
         oe_r     <= 1'b0;
         shown_r  <= 1'b0;
      end else if (!sel) begin
         oe_r <= 1'b0;
         if (cs_n_s) begin
            shown_r <= 1'b0;
         end
      end else if (byte_end) begin
         if (phase_r == PH_CMD && byte_w == STATUS_READ_CMD) begin
            out_sh_r <= status_w;
         end else if (phase_r == PH_STAT_RD) begin
            out_sh_r <= status_w;
         end else if (phase_r == PH_ADDR && abyte_r == LAST_ADDR_BYTE) begin
            out_sh_r <= mem_r[last_addr_w];
         end else if (phase_r == PH_READ) begin
            out_sh_r <= mem_r[addr_r];
         end
      end else if (en_fall && out_ph) begin
         so_r     <= out_sh_r[7];
         out_sh_r <= {out_sh_r[6:0], 1'b0};
         oe_r     <= 1'b1;
         shown_r  <= 1'b1;
      end else if (shown_r && out_ph) begin
         // After a pause the bit that stood before it is driven again.
         oe_r <= 1'b1;
      end
   end

   assign serial_out_out    = so_r;
   assign serial_out_oe_out = oe_r;

   always_ff @(posedge ref_clk_in) begin
      if (byte_end && phase_r == PH_PROG) begin
         pbuf_r[addr_r[7:0]] <= byte_w;
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pmask_r <= '0;
      end else if (byte_end && phase_r == PH_CMD && byte_w == PAGE_PROGRAM_CMD && !busy_w) begin
         pmask_r <= '0;
      end else if (byte_end && phase_r == PH_PROG) begin
         pmask_r[addr_r[7:0]] <= 1'b1;
      end
   end

   // Writes run only on a byte-aligned deselect with the latch set.
   assign exec    = cs_rise & (bit_r == 3'h0);
   assign do_write_enable_cmd = exec & (cmd_r == WRITE_ENABLE_CMD);
   assign do_write_disable_cmd = exec & (cmd_r == WRITE_DISABLE_CMD);
   assign do_pp   = exec & (cmd_r == PAGE_PROGRAM_CMD) & wel_r & data_seen_r & (bp_r != 2'b11);
   assign do_se   = exec & (cmd_r == SECTOR_ERASE_CMD) & wel_r & hdr_done_r & (bp_r != 2'b11);
   assign do_be   = exec & (cmd_r == BULK_ERASE_CMD) & wel_r & ~bp_r[0];
   assign do_status_write_cmd = exec & (cmd_r == STATUS_WRITE_CMD) & wel_r & got_sr_r & ~(srp_r & ~wp_n_s);

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wel_r <= 1'b0;
      end else if (do_write_enable_cmd) begin
         wel_r <= 1'b1;
      end else if (do_write_disable_cmd || do_pp || do_se || do_be || do_status_write_cmd) begin
         wel_r <= 1'b0;
      end
   end

   // Protect bits are not retained across reset in this model.
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         bp_r  <= 2'b00;
         srp_r <= 1'b0;
      end else if (do_status_write_cmd) begin
         bp_r  <= {new_sr_r[BP_HI_BIT], new_sr_r[BP_LO_BIT]};
         srp_r <= new_sr_r[STATUS_PROT_BIT];
      end
   end

   // The engine ignores select entirely, so a started cycle always completes.
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         eng_r  <= ENG_IDLE;
         walk_r <= 17'h0_0000;
         base_r <= 16'h0000;
         len_r  <= 17'h0_0000;
      end else begin
         unique case (eng_r)
            ENG_IDLE: begin
               walk_r <= 17'h0_0000;
               if (do_pp) begin
                  eng_r  <= ENG_PROG;
                  base_r <= {addr_r[15:8], 8'h00};
                  len_r  <= PAGE_BYTES;
               end else if (do_se) begin
                  eng_r  <= ENG_ERASE;
                  base_r <= {addr_r[15], 15'h0000};
                  len_r  <= SECT_BYTES;
               end else if (do_be) begin
                  eng_r  <= ENG_ERASE;
                  base_r <= 16'h0000;
                  len_r  <= MEM_BYTES;
               end else if (do_status_write_cmd) begin
                  eng_r <= ENG_SRWR;
                  len_r <= 17'(srw_cycles);
               end
            end
            ENG_PROG, ENG_ERASE, ENG_SRWR: begin
               walk_r <= walk_r + 17'h0_0001;
               if (walk_r + 17'h0_0001 >= len_r) begin
                  eng_r <= ENG_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (eng_r == ENG_PROG && pmask_r[walk_r[7:0]]) begin
         mem_r[cur_w] <= mem_r[cur_w] & pbuf_r[walk_r[7:0]];
      end else if (eng_r == ENG_ERASE) begin
         mem_r[cur_w] <= ERASED_BYTE;
      end
   end

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!arst_n_in);

   desel_float_a: assert property (cs_n_s |=> !serial_out_oe_out)
      else $error("Output driven while deselected.");
   hold_float_a: assert property (hold_r |=> !serial_out_oe_out)
      else $error("Output driven during pause.");
   rise_sample_a: assert property ((en_rise && bit_r != 3'h7) |=> sh_r[0] == $past(si_s))
      else $error("Input bit not taken on rising edge.");
   fall_drive_a: assert property ($changed(serial_out_out) |-> $past(en_fall))
      else $error("Output changed away from a falling edge.");
   unarmed_idle_a: assert property (!armed_r |-> (phase_r == PH_CMD && bit_r == 3'h0))
      else $error("Activity before select cycled.");
   wel_clear_a: assert property ((do_write_disable_cmd || do_pp || do_se || do_be || do_status_write_cmd) |=> !wel_r)
      else $error("Latch not cleared after write instruction.");
   no_wel_a: assert property ((exec && !wel_r && eng_r == ENG_IDLE) |=> eng_r == ENG_IDLE)
      else $error("Write cycle started without latch.");
   prog_busy_a: assert property (do_pp |=> (busy_w && status_w[BUSY_FLAG_BIT]) [*8])
      else $error("Busy flag missing during program.");
   misalign_a: assert property ((cs_rise && bit_r != 3'h0 && eng_r == ENG_IDLE) |=> eng_r == ENG_IDLE)
      else $error("Unaligned instruction executed.");
   wp_block_a: assert property ((exec && srp_r && !wp_n_s) |=> $stable(bp_r) && $stable(srp_r))
      else $error("Status changed under hardware protection.");
   erase_ones_a: assert property ((eng_r == ENG_ERASE) |=> mem_r[$past(cur_w)] == ERASED_BYTE)
      else $error("Erased byte not all ones.");
   cycle_runs_a: assert property ((eng_r == ENG_ERASE && walk_r + 17'h0_0002 < len_r) |=> eng_r == ENG_ERASE)
      else $error("Erase cycle cut short.");

   prog_c: cover property (do_pp);
   sect_c: cover property (do_se);
   bulk_c: cover property (do_be);
   hold_c: cover property (hold_r && phase_r == PH_READ);
endmodule

// ===== tb/sfl_host_model.sv
// Host SPI master model that drives the serial flash pins.
`timescale 1ns/1ps
module sfl_host_model (
   input  wire logic ref_clk_in,
   input  wire logic so_in,
   input  wire logic so_oe_in,
   output logic      spi_clk_out,
   output logic      chip_sel_n_out,
   output logic      mosi_out,
   output logic      hold_n_out
);
   logic cpol = 1'b0;
   logic pause_oe = 1'b0;
   initial begin
      spi_clk_out    = 1'b0;
      chip_sel_n_out = 1'b0;
      mosi_out       = 1'b0;
      hold_n_out     = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_in);
   endtask
   task automatic start();
      spi_clk_out    <= cpol;
      tick(4);
      chip_sel_n_out <= 1'b0;
      tick(4);
   endtask
   // Output is sampled at the end of the high phase, so a late or early bit fails.
   task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         spi_clk_out <= 1'b0;
         mosi_out    <= tx[i];
         tick(4);
         spi_clk_out <= 1'b1;
         tick(4);
         rx[i] = so_oe_in ? so_in : 1'bx;
      end
   endtask
   // Pause starts and ends with the clock low; the clocks in between must be ignored.
   task automatic pause();
      spi_clk_out <= 1'b0;
      tick(4);
      hold_n_out <= 1'b0;
      tick(4);
      pause_oe = 1'b0;
      repeat (4) begin
         spi_clk_out <= ~spi_clk_out;
         tick(4);
         pause_oe = pause_oe | so_oe_in;
      end
      hold_n_out <= 1'b1;
      tick(4);
   endtask
   task automatic stop();
      tick(4);
      spi_clk_out    <= cpol;
      tick(4);
      chip_sel_n_out <= 1'b1;
      mosi_out       <= ~mosi_out;
      tick(8);
   endtask
endmodule

// ===== tb/tb.sv
// Self-checking bench for the serial flash block.
`timescale 1ns/1ps
module tb import sfl_pkg::*;;
   logic        ref_clk, arst_n = 1'b0, wp_n = 1'b1, sclk, cs_n, mosi, hold_n, so, so_oe;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
   logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q;
   logic [7:0]  r, st, d, exp_pg [256];
   logic [7:0]  sw_val [3] = '{8'h80, 8'h0C, 8'h00};
   logic        sw_wp [3] = '{1'b1, 1'b0, 1'b1};
   int          fail_count = 0, checked = 0, pg, off;
   sfl_host_model host (.ref_clk_in(ref_clk), .so_in(so), .so_oe_in(so_oe), .spi_clk_out(sclk),
      .chip_sel_n_out(cs_n), .mosi_out(mosi), .hold_n_out(hold_n));
   sfl_flash i_sfl_flash (.ref_clk_in(ref_clk), .arst_n_in(arst_n), .spi_clk_in(sclk), .chip_sel_n_in(cs_n),
      .serial_in(mosi), .hold_n_in(hold_n), .write_protect_n_in(wp_n), .serial_out_out(so),
      .serial_out_oe_out(so_oe), .avs_address_in(avs_address), .avs_read_in(avs_read),
      .avs_write_in(avs_write), .avs_writedata_in(avs_writedata), .avs_byteenable_in(4'h3),
      .avs_readdata_out(avs_readdata), .avs_waitrequest_out(avs_waitrequest));
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   function automatic int page_ofs(input int o);
      return o % 256;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic avs(input logic [3:0] a, input logic w, input logic [31:0] dv);
      avs_address   <= a;
      avs_read      <= ~w;
      avs_write     <= w;
      avs_writedata <= dv;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic cmd(input logic [7:0] op);
      host.start();
      host.xfer(op, 8, r);
      host.stop();
   endtask
   task automatic addr_cmd(input logic [7:0] op, input logic [15:0] a);
      host.start();
      host.xfer(op, 8, r);
      host.xfer(8'h00, 8, r);
      host.xfer(a[15:8], 8, r);
      host.xfer(a[7:0], 8, r);
   endtask
   task automatic sread(input bit pz);
      host.start();
      host.xfer(STATUS_READ_CMD, 8, r);
      if (pz) host.pause();
      host.xfer(8'h00, 8, st);
      host.stop();
   endtask
   // Polling is bounded; a stuck busy flag shows up in the status checks that follow.
   task automatic wait_idle();
      q = 32'h0000_0001;
      for (int n = 0; n < 30000 && q[BUSY_FLAG_BIT] !== 1'b0; n++) avs(REG_STATUS_OFS, 1'b0, 32'h0000_0000);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (99000) @(posedge ref_clk);
      fail_count++;
      finish_test();
   end
   initial begin
      void'($urandom(32'h7ab5_c051));
      repeat (4) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      cmd(WRITE_ENABLE_CMD);
      avs(REG_STATUS_OFS, 1'b0, 32'h0000_0000);
      chk("unarmed status", 32'h0000_0000, q);
      $display("test arm done");
      for (int m = 0; m < 2; m++) begin
         host.cpol = m[0];
         cmd(WRITE_ENABLE_CMD);
         sread(1'b1);
         chk("status after enable", 8'h02, st);
         chk("oe in pause", 1'b0, host.pause_oe);
         chk("oe deselected", 1'b0, so_oe);
         cmd(WRITE_DISABLE_CMD);
         sread(1'b0);
         chk("status after disable", 8'h00, st);
      end
      $display("test latch done");
      cmd(BULK_ERASE_CMD);
      avs(REG_STATUS_OFS, 1'b0, 32'h0000_0000);
      chk("erase without latch", 1'b0, q[BUSY_FLAG_BIT]);
      cmd(WRITE_ENABLE_CMD);
      host.start();
      host.xfer(BULK_ERASE_CMD, 8, r);
      host.xfer(8'h00, 3, r);
      host.stop();
      avs(REG_STATUS_OFS, 1'b0, 32'h0000_0000);
      chk("partial byte erase", 1'b0, q[BUSY_FLAG_BIT]);
      cmd(WRITE_ENABLE_CMD);
      cmd(BULK_ERASE_CMD);
      avs(REG_STATUS_OFS, 1'b0, 32'h0000_0000);
      chk("erase busy", 1'b1, q[BUSY_FLAG_BIT]);
      wait_idle();
      chk("latch after erase", 2'b00, q[1:0]);
      $display("test erase done");
      pg  = $urandom % 256;
      off = 240 + $urandom % 16;
      foreach (exp_pg[i]) exp_pg[i] = ERASED_BYTE;
      repeat (2) begin
         cmd(WRITE_ENABLE_CMD);
         addr_cmd(PAGE_PROGRAM_CMD, {pg[7:0], off[7:0]});
         for (int i = 0; i < 32; i++) begin
            d = $urandom;
            exp_pg[page_ofs(off + i)] &= d;
            host.xfer(d, 8, r);
         end
         host.stop();
         wait_idle();
      end
      addr_cmd(READ_DATA_CMD, {pg[7:0], 8'h00});
      for (int i = 0; i < 257; i++) begin
         host.xfer(8'h00, 8, r);
         chk("read byte", (i < 256) ? exp_pg[i] : ERASED_BYTE, r);
      end
      host.stop();
      $display("test program done");
      avs(REG_SRW_OFS, 1'b1, 32'h0000_0100);
      avs(REG_SRW_OFS, 1'b0, 32'h0000_0000);
      chk("srw cycles", 32'h0000_0100, q);
      avs(4'h8, 1'b0, 32'h0000_0000);
      chk("unmapped read", 32'h0000_0000, q);
      for (int i = 0; i < 3; i++) begin
         host.cpol = $urandom % 2;
         wp_n <= sw_wp[i];
         cmd(WRITE_ENABLE_CMD);
         host.start();
         host.xfer(STATUS_WRITE_CMD, 8, r);
         host.xfer(sw_val[i], 8, r);
         host.stop();
         avs(REG_STATUS_OFS, 1'b0, 32'h0000_0000);
         chk("status write busy", i != 1, q[BUSY_FLAG_BIT]);
         wait_idle();
         chk("protect bits", (i == 2) ? 8'h00 : 8'h80, q[7:0] & 8'h8C);
      end
      $display("test protect done");
      finish_test();
   end
endmodule
